//--- design/led_dim_pkg.sv
package led_dim_pkg;
  // ----------------------------------------
  // clocks and timing
  // ----------------------------------------
  localparam int CORE_HZ = 50_000_000;
  localparam int OSC_HZ = 6_000_000;
  localparam int OSC_DIV = CORE_HZ / OSC_HZ;
  localparam int RAMP_UNIT_MS = 50;
  localparam int RAMP_STEPS = 256;
  localparam int RAMP_UNIT_CYCLES = CORE_HZ / 1000 * RAMP_UNIT_MS / RAMP_STEPS;
  localparam int RAMP_MULT_MAX = 160;
  localparam int SCL_LOW_MS = 100;
  localparam int SCL_LOW_CYCLES = CORE_HZ / 1000 * SCL_LOW_MS;
  localparam int EXIT_EDGES = 8;
  localparam int CHANNELS = 4;
  // ----------------------------------------
  // register offsets, keys and fields
  // ----------------------------------------
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_CFG0 = 8'h01;
  localparam logic [7:0] OFS_CFG3 = 8'h04;
  localparam logic [7:0] OFS_SLEEP = 8'h0d;
  localparam logic [7:0] OFS_APPLY = 8'h0f;
  localparam logic [7:0] OFS_FLAG_CLR = 8'h13;
  localparam logic [7:0] OFS_GAIN = 8'h14;
  localparam logic [7:0] OFS_DUTY = 8'h18;
  localparam logic [7:0] SLEEP_KEY = 8'h33;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [8:0] RAMP_DONE = 9'h100;
  localparam logic [4:0] PIN_IDLE = 5'h0c;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_PEAK = 0;
  localparam int BIT_PU_CLR = 0;
  localparam int BIT_OT_CLR = 1;
  localparam int RAMP_CODE_LSB = 4;
  localparam int CURVE_LSB = 4;

  typedef enum logic [2:0] {M_POR, M_INIT, M_STANDBY, M_NORMAL, M_OVERTEMP, M_SHUTDOWN} mode_t;

  // ramp duration as a multiple of 50 ms
  function automatic logic [7:0] ramp_mult(input logic [3:0] code);
    case (code)
      4'hb: ramp_mult = 8'd20;
      4'hc: ramp_mult = 8'd40;
      4'hd: ramp_mult = 8'd80;
      4'he: ramp_mult = 8'd120;
      4'hf: ramp_mult = 8'd160;
      default: ramp_mult = {4'h0, code};
    endcase
  endfunction : ramp_mult

  // step k of 256 between start and end, exact at k = 256
  function automatic logic [7:0] ramp_interp(input logic [7:0] s, input logic [7:0] e, input logic [8:0] k);
    logic signed [9:0] diff;
    logic signed [19:0] prod;
    logic [11:0] sum;
    diff = $signed({2'b00, e}) - $signed({2'b00, s});
    prod = diff * $signed({1'b0, k});
    sum = {4'h0, s} + prod[19:8];
    ramp_interp = sum[7:0];
  endfunction : ramp_interp

  // piecewise exponential: mantissa of 5 bits, exponent of 3
  function automatic logic [7:0] exp_curve(input logic [7:0] v);
    logic [12:0] t;
    t = 13'({1'b1, v[4:0]}) << v[7:5];
    exp_curve = (v == 8'h00) ? 8'h00 : t[12:5];
  endfunction : exp_curve
endpackage : led_dim_pkg

//--- design/link_write_port.sv
`timescale 1ns/100ps
`default_nettype none
module link_write_port (
  input wire logic link_clk_i,
  input wire logic link_rst_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  output logic req_tgl_o,
  output logic [7:0] req_addr_o,
  output logic [7:0] req_data_o,
  input wire logic ack_tgl_i
);
  // ----------------------------------------
  // ack crossing, three stages
  // ----------------------------------------
  logic ack_s1, ack_s2, ack_s3, ack_clean;
  wire logic take;
  wire logic ack_evt;
  assign take = wr_valid_i & wr_ready_o;
  assign ack_evt = (ack_s2 == ack_s3) & (ack_s2 != ack_clean);

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst_i)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      ack_clean <= 1'b0;
    end
    else
    begin
      ack_s1 <= ack_tgl_i;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ack_evt)
        ack_clean <= ack_s2;
    end
  end

  // ----------------------------------------
  // request hold: address and data stay put until acked
  // ----------------------------------------
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst_i)
    begin
      wr_ready_o <= 1'b1;
      req_tgl_o <= 1'b0;
      req_addr_o <= 8'h00;
      req_data_o <= 8'h00;
    end
    else if (take)
    begin
      wr_ready_o <= 1'b0;
      req_tgl_o <= ~req_tgl_o;
      req_addr_o <= wr_addr_i;
      req_data_o <= wr_data_i;
    end
    else if (ack_evt)
      wr_ready_o <= 1'b1;
  end
endmodule : link_write_port
`default_nettype wire

//--- design/rgbw_led_dimming_core.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - one shared peak-current bit, 0 is low range, 1 high, reset 0
// - per-channel 8-bit gain level, default zero
// - 8-bit pwm per channel clocked by a roughly 6 MHz tick
// - each channel takes its duty from its own duty setting
// - ramp off: output duty follows the latest setting at once
// - ramp on: duty glides to the latest setting within the chosen time
// - per-channel choice of exponential or linear duty curve
// - a ramp takes 256 steps, also with the exponential curve
// - 4-bit ramp code gives 0 to 0.5 s in 50 ms, then 1,2,4,6,8 s
// - supply low holds power-on reset, release enters init and flags power-up
// - power-up flag stays until cleared by write while enabled
// - over-temperature turns outputs off and sets its flag, release restores
// - over-temperature flag stays until cleared by write while enabled or by entry into init
// - init is entered on supply release or on leaving shutdown
// - init restores register defaults and sets power-up flag on exit
// - after init or over-temperature go standby or normal by enable
// - writing 33h to address 0Dh enters shutdown from active modes
// - eight data falls with clock high leave shutdown
// - clock low 100 ms with data high enters shutdown
// - one clock rising edge leaves shutdown
// - over-temperature keeps outputs off but both shutdown entries work
// - config registers 01h to 04h act only after apply, while enabled
module rgbw_led_dimming_core #(
  parameter int RAMP_UNIT_CYCLES = led_dim_pkg::RAMP_UNIT_CYCLES,
  parameter int SCL_LOW_CYCLES = led_dim_pkg::SCL_LOW_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic link_rst_i,
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic supply_low_lockout_i,
  input wire logic over_temp_i,
  output logic [3:0] chan_pwm_o,
  output logic [31:0] channel_gain_level_o,
  output logic peak_current_code_o,
  output logic power_up_flag_o,
  output logic over_temp_flag_o,
  output logic [2:0] mode_o
);
  localparam int SCLW = $clog2(SCL_LOW_CYCLES + 1);
  localparam int RAMPW = $clog2(RAMP_UNIT_CYCLES * led_dim_pkg::RAMP_MULT_MAX + 1);
  localparam logic [SCLW-1:0] SCL_LAST = SCLW'(SCL_LOW_CYCLES - 1);
  localparam logic [3:0] EXIT_LAST = 4'(led_dim_pkg::EXIT_EDGES - 1);
  localparam logic [3:0] OSC_LAST = 4'(led_dim_pkg::OSC_DIV - 1);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // link side write port
  // ----------------------------------------
  logic req_tgl;
  logic ack_tgl;
  logic [7:0] req_addr, req_data;

  link_write_port u_link (
    .link_clk_i(link_clk_i),
    .link_rst_i(link_rst_i),
    .wr_valid_i(wr_valid_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .wr_ready_o(wr_ready_o),
    .req_tgl_o(req_tgl),
    .req_addr_o(req_addr),
    .req_data_o(req_data),
    .ack_tgl_i(ack_tgl)
  );

  // ----------------------------------------
  // input crossing, a change counts once stages two and three agree
  // ----------------------------------------
  logic [4:0] pin_s1, pin_s2, pin_s3, pin_clean, pin_prev;
  wire logic [4:0] pin_raw;
  wire logic [4:0] agree;
  assign pin_raw = {req_tgl, scl_i, sda_i, supply_low_lockout_i, over_temp_i};
  assign agree = ~(pin_s2 ^ pin_s3);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= led_dim_pkg::PIN_IDLE;
      pin_s2 <= led_dim_pkg::PIN_IDLE;
      pin_s3 <= led_dim_pkg::PIN_IDLE;
      pin_clean <= led_dim_pkg::PIN_IDLE;
      pin_prev <= led_dim_pkg::PIN_IDLE;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (pin_s2 & agree) | (pin_clean & ~agree);
      pin_prev <= pin_clean;
    end
  end

  wire logic sclc, sdac, lowc, hotc, scl_rise, sda_fall, req_evt;
  assign sclc = pin_clean[3];
  assign sdac = pin_clean[2];
  assign lowc = pin_clean[1];
  assign hotc = pin_clean[0];
  assign scl_rise = sclc & ~pin_prev[3];
  assign sda_fall = ~sdac & pin_prev[2];
  assign req_evt = pin_clean[4] ^ pin_prev[4];

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  led_dim_pkg::mode_t mode, next_mode;
  logic enable_reg;
  logic [7:0] shadow [4];
  logic [7:0] duty [4];
  wire logic active_mode, wr_fire, hit_cfg, hit_gain, hit_duty, apply_fire, flag_wr, reg_clear;
  wire logic [1:0] cfg_idx, ch_idx;
  wire logic [7:0] cfg_ofs;
  assign active_mode = (mode == led_dim_pkg::M_STANDBY) | (mode == led_dim_pkg::M_NORMAL) |
                       (mode == led_dim_pkg::M_OVERTEMP);
  // the serial side keeps working in over-temperature
  assign wr_fire = req_evt & active_mode;
  assign cfg_ofs = req_addr - led_dim_pkg::OFS_CFG0;
  assign cfg_idx = cfg_ofs[1:0];
  assign ch_idx = req_addr[1:0];
  assign hit_cfg = (req_addr >= led_dim_pkg::OFS_CFG0) & (req_addr <= led_dim_pkg::OFS_CFG3);
  assign hit_gain = req_addr[7:2] == led_dim_pkg::OFS_GAIN[7:2];
  assign hit_duty = req_addr[7:2] == led_dim_pkg::OFS_DUTY[7:2];
  assign apply_fire = wr_fire & (req_addr == led_dim_pkg::OFS_APPLY) & enable_reg;
  assign flag_wr = wr_fire & (req_addr == led_dim_pkg::OFS_FLAG_CLR) & enable_reg;
  // defaults return on the way into init
  assign reg_clear = rst_i | (next_mode == led_dim_pkg::M_INIT);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ack_tgl <= 1'b0;
    else
      ack_tgl <= ack_tgl ^ req_evt;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (reg_clear)
    begin
      enable_reg <= 1'b0;
      channel_gain_level_o <= {4{led_dim_pkg::REG_RST}};
      for (int i = 0; i < 4; i++)
      begin
        shadow[i] <= led_dim_pkg::REG_RST;
        duty[i] <= led_dim_pkg::REG_RST;
      end
    end
    else if (wr_fire)
    begin
      if (req_addr == led_dim_pkg::OFS_ENABLE)
        enable_reg <= req_data[led_dim_pkg::BIT_ENABLE];
      if (hit_cfg)
        shadow[cfg_idx] <= req_data;
      if (hit_gain)
        channel_gain_level_o[8*ch_idx +: 8] <= req_data;
      if (hit_duty)
        duty[ch_idx] <= req_data;
    end
  end

  // ----------------------------------------
  // applied configuration
  // ----------------------------------------
  logic [3:0] out_en_act, ramp_en_act, log_act, ramp_code_act;

  always_ff @(posedge core_clk_i)
  begin
    if (reg_clear)
    begin
      peak_current_code_o <= 1'b0;
      out_en_act <= 4'h0;
      ramp_en_act <= 4'h0;
      ramp_code_act <= 4'h0;
      log_act <= 4'h0;
    end
    else if (apply_fire)
    begin
      peak_current_code_o <= shadow[0][led_dim_pkg::BIT_PEAK];
      out_en_act <= shadow[1][3:0];
      ramp_en_act <= shadow[2][3:0];
      ramp_code_act <= shadow[2][led_dim_pkg::RAMP_CODE_LSB +: 4];
      log_act <= shadow[3][led_dim_pkg::CURVE_LSB +: 4];
    end
  end

  // ----------------------------------------
  // shutdown entry and exit detectors
  // ----------------------------------------
  logic [SCLW-1:0] scl_low_cnt;
  logic [3:0] exit_cnt;
  wire logic hold_cond, scl_hold_hit, sleep_req, wake_req, shut_mode;
  assign shut_mode = mode == led_dim_pkg::M_SHUTDOWN;
  assign hold_cond = ~sclc & sdac & active_mode;
  assign scl_hold_hit = hold_cond & (scl_low_cnt == SCL_LAST);
  assign sleep_req = active_mode & (scl_hold_hit | (wr_fire & (req_addr == led_dim_pkg::OFS_SLEEP) &
                     (req_data == led_dim_pkg::SLEEP_KEY)));
  assign wake_req = shut_mode & (scl_rise | (sda_fall & sclc & (exit_cnt == EXIT_LAST)));

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !hold_cond)
      scl_low_cnt <= '0;
    else if (scl_low_cnt != SCL_LAST)
      scl_low_cnt <= scl_low_cnt + 1'b1;
  end

  // a low clock line breaks the sequence of data falls
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !shut_mode || !sclc)
      exit_cnt <= 4'h0;
    else if (sda_fall)
      exit_cnt <= exit_cnt + 4'h1;
  end

  // ----------------------------------------
  // mode state machine
  // ----------------------------------------
  wire led_dim_pkg::mode_t settle_mode;
  assign settle_mode = enable_reg ? led_dim_pkg::M_NORMAL : led_dim_pkg::M_STANDBY;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      led_dim_pkg::M_POR: next_mode = led_dim_pkg::M_INIT;
      led_dim_pkg::M_INIT: next_mode = settle_mode;
      led_dim_pkg::M_STANDBY, led_dim_pkg::M_NORMAL:
      begin
        if (sleep_req)
          next_mode = led_dim_pkg::M_SHUTDOWN;
        else if (hotc)
          next_mode = led_dim_pkg::M_OVERTEMP;
        else
          next_mode = settle_mode;
      end
      led_dim_pkg::M_OVERTEMP:
      begin
        if (sleep_req)
          next_mode = led_dim_pkg::M_SHUTDOWN;
        else if (!hotc)
          next_mode = settle_mode;
      end
      led_dim_pkg::M_SHUTDOWN:
      begin
        if (wake_req)
          next_mode = led_dim_pkg::M_INIT;
      end
      default: next_mode = led_dim_pkg::M_POR;
    endcase
    if (lowc)
      next_mode = led_dim_pkg::M_POR;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      mode <= led_dim_pkg::M_POR;
    else
      mode <= next_mode;
  end

  assign mode_o = mode;

  // ----------------------------------------
  // flags: a set in the same cycle as a clear wins
  // ----------------------------------------
  wire logic ot_set;
  assign ot_set = (next_mode == led_dim_pkg::M_OVERTEMP) & (mode != led_dim_pkg::M_OVERTEMP);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      power_up_flag_o <= 1'b0;
    else if (mode == led_dim_pkg::M_INIT)
      power_up_flag_o <= 1'b1;
    else if (flag_wr && req_data[led_dim_pkg::BIT_PU_CLR])
      power_up_flag_o <= 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reg_clear)
      over_temp_flag_o <= 1'b0;
    else if (ot_set)
      over_temp_flag_o <= 1'b1;
    else if (flag_wr && req_data[led_dim_pkg::BIT_OT_CLR])
      over_temp_flag_o <= 1'b0;
  end

  // ----------------------------------------
  // ramp timebase, shared by all channels
  // ----------------------------------------
  logic [RAMPW-1:0] ramp_cnt;
  wire logic [RAMPW-1:0] ramp_interval;
  wire logic [RAMPW-1:0] ramp_cnt_inc;
  wire logic ramp_tick;
  assign ramp_interval = RAMPW'(RAMP_UNIT_CYCLES) * RAMPW'(led_dim_pkg::ramp_mult(ramp_code_act));
  assign ramp_cnt_inc = ramp_cnt + 1'b1;
  assign ramp_tick = ramp_cnt_inc >= ramp_interval;

  always_ff @(posedge core_clk_i)
  begin
    if (reg_clear || ramp_tick)
      ramp_cnt <= '0;
    else
      ramp_cnt <= ramp_cnt_inc;
  end

  // ----------------------------------------
  // per-channel ramp
  // ----------------------------------------
  logic [7:0] cur_duty [4];
  logic [7:0] ramp_start [4];
  logic [7:0] ramp_end [4];
  logic [8:0] ramp_k [4];
  wire logic [3:0] tgt_new, jump;
  wire logic [7:0] shown [4];
  wire logic [3:0] pwm_on;
  logic [7:0] pwm_cnt;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      assign tgt_new[g] = duty[g] != ramp_end[g];
      assign jump[g] = ~ramp_en_act[g] | (tgt_new[g] & (ramp_code_act == 4'h0));
      assign shown[g] = log_act[g] ? led_dim_pkg::exp_curve(cur_duty[g]) : cur_duty[g];
      assign pwm_on[g] = (mode == led_dim_pkg::M_NORMAL) & out_en_act[g] & (pwm_cnt < shown[g]);
    end
  endgenerate

  always_ff @(posedge core_clk_i)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (reg_clear)
      begin
        cur_duty[i] <= 8'h00;
        ramp_start[i] <= 8'h00;
        ramp_end[i] <= 8'h00;
        ramp_k[i] <= led_dim_pkg::RAMP_DONE;
      end
      else if (jump[i])
      begin
        cur_duty[i] <= duty[i];
        ramp_start[i] <= duty[i];
        ramp_end[i] <= duty[i];
        ramp_k[i] <= led_dim_pkg::RAMP_DONE;
      end
      else if (tgt_new[i])
      begin
        ramp_start[i] <= cur_duty[i];
        ramp_end[i] <= duty[i];
        ramp_k[i] <= 9'h000;
      end
      else if (ramp_tick && ramp_k[i] != led_dim_pkg::RAMP_DONE)
      begin
        ramp_k[i] <= ramp_k[i] + 9'h001;
        cur_duty[i] <= led_dim_pkg::ramp_interp(ramp_start[i], ramp_end[i], ramp_k[i] + 9'h001);
      end
    end
  end

  // ----------------------------------------
  // pwm engine
  // ----------------------------------------
  // 50 MHz over 8 gives 6.25 MHz, so the frame lands near 24 kHz
  logic [3:0] osc_cnt;
  wire logic osc_tick;
  assign osc_tick = osc_cnt == OSC_LAST;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      osc_cnt <= 4'h0;
      pwm_cnt <= 8'h00;
      chan_pwm_o <= 4'h0;
    end
    else
    begin
      osc_cnt <= osc_tick ? 4'h0 : osc_cnt + 4'h1;
      pwm_cnt <= pwm_cnt + {7'h00, osc_tick};
      chan_pwm_o <= pwm_on;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  osc_spacing_a: assert property (osc_tick |=> !osc_tick [*7] ##1 osc_tick)
    else $error("oscillator tick spacing wrong");
  peak_apply_a: assert property (apply_fire |=> peak_current_code_o == $past(shadow[0][0]))
    else $error("peak current not applied");
  duty_jump_a: assert property ((jump[0] && !reg_clear) |=> cur_duty[0] == $past(duty[0]))
    else $error("duty did not follow setting");
  ramp_restart_a: assert property ((!jump[0] && tgt_new[0] && !reg_clear) |=>
    (ramp_start[0] == $past(cur_duty[0])) && (ramp_k[0] == 9'h000))
    else $error("ramp did not restart from present duty");
  ramp_end_a: assert property ((ramp_k[0] == 9'h100) |-> cur_duty[0] == ramp_end[0])
    else $error("ramp finished off target");
  hot_off_a: assert property ((mode == led_dim_pkg::M_OVERTEMP) |=> chan_pwm_o == 4'h0)
    else $error("outputs on during over-temperature");
  por_hold_a: assert property (lowc |=> mode == led_dim_pkg::M_POR)
    else $error("supply low did not hold reset");
  init_flag_a: assert property ((mode == led_dim_pkg::M_INIT) |=> power_up_flag_o ##1 power_up_flag_o)
    else $error("power-up flag not set after init");
  pu_keep_a: assert property ((!enable_reg && mode != led_dim_pkg::M_INIT) |=>
    power_up_flag_o >= $past(power_up_flag_o))
    else $error("power-up flag cleared while disabled");
  shut_cmd_a: assert property ((wr_fire && req_addr == led_dim_pkg::OFS_SLEEP &&
    req_data == led_dim_pkg::SLEEP_KEY && !lowc) |=> mode == led_dim_pkg::M_SHUTDOWN)
    else $error("shutdown command ignored");
  scl_hold_a: assert property ((scl_hold_hit && !lowc) |=> mode == led_dim_pkg::M_SHUTDOWN)
    else $error("clock hold did not shut down");
  scl_wake_a: assert property ((shut_mode && scl_rise && !lowc) |=> mode == led_dim_pkg::M_INIT)
    else $error("clock rise did not wake");
  sda_wake_a: assert property ((shut_mode && sclc && sda_fall && exit_cnt == EXIT_LAST && !lowc) |=>
    mode == led_dim_pkg::M_INIT)
    else $error("eighth data fall did not wake");
endmodule : rgbw_led_dimming_core
`default_nettype wire

//--- design/unused_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic link_clk_i,
  input wire logic wr_ready_i,
  output logic wr_valid_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    wr_valid_o = 1'b0;
    wr_addr_o = 8'hff;
    wr_data_o = 8'hff;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one write at a time, held until taken, then wait for ready to return
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge link_clk_i);
    #1;
    wr_valid_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    do @(posedge link_clk_i); while (wr_ready_i !== 1'b1);
    #1;
    wr_valid_o = 1'b0;
    // released lines show the inverse so a stale value cannot pass
    wr_addr_o = ~a;
    wr_data_o = ~d;
    repeat (2) @(posedge link_clk_i);
    while (wr_ready_i !== 1'b1) @(posedge link_clk_i);
  endtask : write
  task automatic pins(input logic s, input logic d);
    scl_o = s;
    sda_o = d;
  endtask : pins
endmodule : host_model
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst, lclk, lrst, low, hot;
  wire logic wr_valid, wr_ready, scl, sda, peak, pu, ot;
  wire logic [7:0] wr_addr, wr_data;
  wire logic [3:0] pwm;
  wire logic [31:0] gain;
  wire logic [2:0] mode;
  int mismatches, comparisons, cycles;
  int on_cnt[4];
  // ----------------------------------------
  // clocks, design and far side
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #32 lclk = ~lclk;
  end
  rgbw_led_dimming_core #(.RAMP_UNIT_CYCLES(4), .SCL_LOW_CYCLES(50)) dut (
    .core_clk_i(clk), .rst_i(rst), .link_clk_i(lclk), .link_rst_i(lrst),
    .wr_valid_i(wr_valid), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_ready_o(wr_ready),
    .scl_i(scl), .sda_i(sda), .supply_low_lockout_i(low), .over_temp_i(hot),
    .chan_pwm_o(pwm), .channel_gain_level_o(gain), .peak_current_code_o(peak),
    .power_up_flag_o(pu), .over_temp_flag_o(ot), .mode_o(mode)
  );
  host_model host (
    .link_clk_i(lclk), .wr_ready_i(wr_ready), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .scl_o(scl), .sda_o(sda)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      $display("ERROR %0t timeout", $time);
      mismatches++;
      give_verdict;
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write(a, d);
    tick(4);
  endtask : wr
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 300 && mode !== m; i++) tick(1);
    chk(mode, m);
  endtask : wait_mode
  // one full pwm period is 256 ticks of 8 core cycles
  task automatic measure;
    on_cnt = '{0, 0, 0, 0};
    // sampled 1 ns after each edge from the first edge on, with no wait for a mode change to settle
    repeat (2048)
    begin
      @(posedge clk);
      #1;
      for (int c = 0; c < 4; c++) on_cnt[c] += pwm[c];
    end
  endtask : measure
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_start;
    wait_mode(led_dim_pkg::M_STANDBY);
    chk(pu, 1);
    chk({peak, ot, gain}, 0);
    wr(8'h13, 8'h01);
    chk(pu, 1);
    wr(8'h00, 8'h01);
    wait_mode(led_dim_pkg::M_NORMAL);
    wr(8'h13, 8'h01);
    chk(pu, 0);
    wr(8'h01, 8'h01);
    chk(peak, 0);
    wr(8'h0f, 8'h00);
    chk(peak, 1);
    wr(8'h16, 8'ha5);
    chk(gain, 32'h00a50000);
  endtask : t_start
  task automatic t_pwm;
    wr(8'h02, 8'h0f);
    wr(8'h04, 8'h80);
    wr(8'h0f, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h19, 8'h40);
    wr(8'h1a, 8'hff);
    wr(8'h1b, 8'h80);
    measure;
    chk(on_cnt[0], 0);
    chk(on_cnt[1], 32'h200);
    chk(on_cnt[2], 32'h7f8);
    chk(on_cnt[3], 32'h80);
    wr(8'h03, 8'h11);
    wr(8'h0f, 8'h00);
    wr(8'h18, 8'hff);
    measure;
    chk(on_cnt[0] < 2040, 1);
    measure;
    chk(on_cnt[0], 32'h7f8);
  endtask : t_pwm
  task automatic t_hot;
    hot = 1'b1;
    wait_mode(led_dim_pkg::M_OVERTEMP);
    chk(ot, 1);
    measure;
    chk(on_cnt[2], 0);
    hot = 1'b0;
    wait_mode(led_dim_pkg::M_NORMAL);
    chk(ot, 1);
    measure;
    chk(on_cnt[2], 32'h7f8);
    wr(8'h13, 8'h02);
    chk(ot, 0);
    hot = 1'b1;
    wait_mode(led_dim_pkg::M_OVERTEMP);
    wr(8'h0d, 8'h33);
    wait_mode(led_dim_pkg::M_SHUTDOWN);
    hot = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7) chk(mode, led_dim_pkg::M_SHUTDOWN);
      host.pins(1'b1, 1'b0);
      tick(250);
      host.pins(1'b1, 1'b1);
      tick(250);
    end
    wait_mode(led_dim_pkg::M_STANDBY);
    chk({pu, gain}, 33'h100000000);
  endtask : t_hot
  task automatic t_pins;
    host.pins(1'b0, 1'b1);
    tick(40);
    chk(mode, led_dim_pkg::M_STANDBY);
    wait_mode(led_dim_pkg::M_SHUTDOWN);
    tick(20);
    host.pins(1'b1, 1'b0);
    wait_mode(led_dim_pkg::M_STANDBY);
    // clear the flag first so the lockout release has to set it again
    wr(8'h00, 8'h01);
    wr(8'h13, 8'h01);
    chk(pu, 0);
    low = 1'b1;
    wait_mode(led_dim_pkg::M_POR);
    low = 1'b0;
    wait_mode(led_dim_pkg::M_STANDBY);
    chk(pu, 1);
  endtask : t_pins
  initial
  begin
    rst = 1'b1;
    lrst = 1'b1;
    low = 1'b0;
    hot = 1'b0;
    tick(4);
    rst = 1'b0;
    // the link side needs a second edge of its own clock inside reset
    @(posedge lclk);
    #1;
    lrst = 1'b0;
    t_start;
    t_pwm;
    t_hot;
    t_pins;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
